// >>> dv/alarm_handler_chk.sv
// Port checker of the alarm handler.
// Assumes it is bound into alarm_handler_with_history.
`timescale 1ns/1ps
`default_nettype none

module alarm_handler_chk #(
  parameter logic [7:0] ABS_POS_CODE = 8'h00
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Requests
  input wire logic alarmRaise,
  input wire logic [15:0] controlWord,
  input wire logic alarmClearInput,
  input wire logic presetDone,
  input wire logic homingDone,
  input wire alarm_pkg::obj_req_type objReq,
  // Answers
  input wire logic objAck_q,
  input wire logic objError_q,
  input wire logic [31:0] objRdata_q,
  input wire logic alarmOutputA_q,
  input wire logic alarmOutputB_q,
  input wire logic motorStop_q,
  input wire logic motorExcite_q,
  input wire logic powerFaultLampRed_q,
  input wire logic alarmActive_q,
  input wire logic [7:0] activeCode_q
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  logic clearable;
  logic histRead;
  // A raise in the same cycle wins over any clear, so it is excluded
  assign clearable = alarmActive_q && !alarmRaise && activeCode_q != 8'h20;
  assign histRead = objReq.read && objReq.index >= 16'h4041 && objReq.index <= 16'h404A;

  // ----
  // Checks
  // ----
  raise_outs_a: assert property (alarmRaise |-> ##2 alarmOutputA_q && motorStop_q)
    else $error("outputs not set after raise");
  no_excite_a: assert property (alarmOutputA_q |-> !motorExcite_q && !alarmOutputB_q)
    else $error("motor excited during alarm");
  red_start_a: assert property (alarmRaise && !alarmActive_q |=> powerFaultLampRed_q)
    else $error("red lamp late");
  fault_reset_a: assert property (clearable && $rose(controlWord[7]) |-> ##2 !alarmOutputA_q)
    else $error("fault reset edge ignored");
  clear_edge_a: assert property (clearable && $rose(alarmClearInput) |-> ##2 !alarmOutputA_q)
    else $error("clear input edge ignored");
  locked_hold_a: assert property (activeCode_q == 8'h20 |=> alarmActive_q)
    else $error("locked alarm released");
  abs_clear_a: assert property ((presetDone || homingDone) && clearable &&
    activeCode_q == ABS_POS_CODE |-> ##2 !alarmOutputA_q) else $error("position alarm kept");
  obj_ack_a: assert property (objReq.read || objReq.write |-> ##2 objAck_q)
    else $error("object answer timing");
  bad_sub_a: assert property (histRead && objReq.sub > 8'h0F |-> ##2 objError_q)
    else $error("text field served");
  sub_zero_a: assert property (histRead && objReq.sub == 8'h00 |-> ##2 objRdata_q == 32'h0F)
    else $error("field count wrong");
  cover property (alarmRaise);
  cover property (objReq.write && objReq.index == 16'h40C2);
  cover property (activeCode_q == 8'h20);
endmodule

bind alarm_handler_with_history alarm_handler_chk #(.ABS_POS_CODE(ABS_POS_CODE)) u_chk (
  .clock(clock), .rst_b(rst_b), .alarmRaise(alarmRaise), .controlWord(controlWord),
  .alarmClearInput(alarmClearInput), .presetDone(presetDone), .homingDone(homingDone),
  .objReq(objReq), .objAck_q(objAck_q), .objError_q(objError_q), .objRdata_q(objRdata_q),
  .alarmOutputA_q(alarmOutputA_q), .alarmOutputB_q(alarmOutputB_q), .motorStop_q(motorStop_q),
  .motorExcite_q(motorExcite_q), .powerFaultLampRed_q(powerFaultLampRed_q),
  .alarmActive_q(alarmActive_q), .activeCode_q(activeCode_q));
`default_nettype wire

// >>> dv/alarm_handler_with_history_test.sv
// Self-checking bench of the alarm handler with history.
// Assumes the master model drives objects, control word and clear input.
`timescale 1ns/1ps
`default_nettype none

module alarm_handler_with_history_test;
  localparam logic [7:0] ABS_CODE = 8'h31;
  logic clock, rst_b, alarmRaise, presetDone, homingDone, operationRunning, mainPowerOn;
  logic alarmClearInput, objAck_q, objError_q, rerr, outA, outB, stop, excite, green, red, act;
  logic [7:0] alarmCode, alarmSubCode, code;
  logic [15:0] controlWord, physicalInputs, remoteOutputs;
  logic [31:0] objRdata_q, rdata, opOld;
  alarm_pkg::context_type ctx;
  alarm_pkg::obj_req_type objReq;
  int bad_count, check_count, cycles, i;

  alarm_handler_with_history #(.DEPTH(10), .ABS_POS_CODE(ABS_CODE), .BLINK_CYCLES(4),
    .TICK_CYCLES(3)) DUT (.clock(clock), .rst_b(rst_b), .alarmRaise(alarmRaise),
    .alarmCode(alarmCode), .alarmSubCode(alarmSubCode), .alarmContext(ctx),
    .controlWord(controlWord), .alarmClearInput(alarmClearInput), .presetDone(presetDone),
    .homingDone(homingDone), .physicalInputs(physicalInputs), .remoteOutputs(remoteOutputs),
    .operationRunning(operationRunning), .mainPowerOn(mainPowerOn), .objReq(objReq),
    .objAck_q(objAck_q), .objError_q(objError_q), .objRdata_q(objRdata_q),
    .alarmOutputA_q(outA), .alarmOutputB_q(outB), .motorStop_q(stop), .motorExcite_q(excite),
    .powerFaultLampGreen_q(green), .powerFaultLampRed_q(red), .alarmActive_q(act),
    .activeCode_q(code));
  alarm_master_model u_master (.clock(clock), .objAck_q(objAck_q), .objError_q(objError_q),
    .objRdata_q(objRdata_q), .objReq(objReq), .controlWord(controlWord),
    .alarmClearInput(alarmClearInput));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // A hang is cut short well beyond the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ----
  // Tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp,
                    input logic expErr);
    u_master.access(1'b0, idx, sub, 32'h0, rdata, rerr);
    check(rdata, exp);
    check({31'h0, rerr}, {31'h0, expErr});
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] wd, input logic expErr);
    u_master.access(1'b1, idx, 8'h00, wd, rdata, rerr);
    check({31'h0, rerr}, {31'h0, expErr});
  endtask

  task automatic raise(input logic [7:0] c, input logic [7:0] s);
    @(posedge clock);
    #1 alarmRaise = 1'b1;
    alarmCode = c;
    alarmSubCode = s;
    @(posedge clock);
    #1 alarmRaise = 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Boot time (field 11) is skipped; op and main times read 0 with both levels low
  function automatic logic [31:0] expField(input logic [7:0] c, input logic [7:0] s, input int f);
    case (f)
      0: return 32'h0000_000F;
      1: return {24'h0, c};
      2: return {24'h0, s};
      3: return {16'h0, ctx.driverTemp};
      4: return {16'h0, ctx.motorTemp};
      5: return {16'h0, ctx.inverterVolt};
      6: return {16'h0, physicalInputs};
      7: return {16'h0, remoteOutputs};
      8: return {16'h0, ctx.opDataNum};
      9: return {16'h0, ctx.opKind};
      10: return ctx.feedbackPos;
      14: return ctx.motorModel;
      15: return ctx.motorSerial;
      default: return 32'h0;
    endcase
  endfunction

  // ----
  // Sequence
  // ----
  initial begin
    rst_b = 1'b0;
    alarmRaise = 1'b0;
    alarmCode = 8'h00;
    alarmSubCode = 8'h00;
    presetDone = 1'b0;
    homingDone = 1'b0;
    operationRunning = 1'b0;
    mainPowerOn = 1'b0;
    physicalInputs = 16'h8021;
    remoteOutputs = 16'h40C0;
    ctx = '{16'h0031, 16'h0042, 16'h0300, 32'hFFFF_F00A, 16'h0007, 16'h0002, 32'hA5A5_0001,
            32'h0000_1234};
    repeat (20) @(posedge clock);
    #1 rst_b = 1'b1;
    repeat (5) @(posedge clock);
    #1;
    check({29'h0, outB, excite, green}, 32'h7);
    rd(16'h4041, 8'h01, 32'h0, 1'b0);
    rd(16'h4040, 8'h01, 32'h0, 1'b1);
    wr(16'h4041, 32'h1, 1'b1);
    raise(8'h10, 8'h55);
    check({28'h0, outA, outB, stop, excite}, 32'hA);
    check({21'h0, act, code, red, green}, 32'h442);
    for (i = 0; i < 16; i++) begin
      if (i != 11) rd(16'h4041, i[7:0], expField(8'h10, 8'h55, i), 1'b0);
    end
    rd(16'h4041, 8'h10, 32'h0, 1'b1);
    u_master.faultReset();
    check({22'h0, outA, act, code}, 32'h0);
    u_master.setClear(1'b1);
    raise(8'h70, 8'h03);
    repeat (8) @(posedge clock);
    #1;
    check({31'h0, outA}, 32'h1);
    rd(16'h4041, 8'h02, 32'h3, 1'b0);
    u_master.setClear(1'b0);
    u_master.setClear(1'b1);
    check({31'h0, outA}, 32'h0);
    u_master.setClear(1'b0);
    for (i = 0; i < 2; i++) begin
      raise(ABS_CODE, 8'h00);
      presetDone = (i == 0);
      homingDone = (i == 1);
      @(posedge clock);
      #1 presetDone = 1'b0;
      homingDone = 1'b0;
      repeat (2) @(posedge clock);
      #1;
      check({31'h0, outA}, 32'h0);
    end
    raise(8'h20, 8'h00);
    repeat (4) @(posedge clock);
    #1 check({31'h0, red}, 32'h0);
    repeat (4) @(posedge clock);
    #1 check({31'h0, red}, 32'h1);
    u_master.faultReset();
    u_master.setClear(1'b1);
    u_master.setClear(1'b0);
    check({31'h0, outA}, 32'h1);
    rst_b = 1'b0;
    repeat (2) @(posedge clock);
    #1 rst_b = 1'b1;
    repeat (5) @(posedge clock);
    #1;
    check({31'h0, outA}, 32'h0);
    operationRunning = 1'b1;
    mainPowerOn = 1'b1;
    for (i = 0; i <= 10; i++) begin
      physicalInputs = 16'h0200 + i[15:0];
      remoteOutputs = 16'h0100 + i[15:0];
      raise(8'h40 + i[7:0], 8'h00);
      u_master.faultReset();
    end
    for (i = 0; i < 10; i++) begin
      rd(16'h4041 + i[15:0], 8'h01, {24'h0, 8'h4A - i[7:0]}, 1'b0);
      rd(16'h4041 + i[15:0], 8'h06, {16'h0, 16'h020A - i[15:0]}, 1'b0);
      rd(16'h4041 + i[15:0], 8'h07, {16'h0, 16'h010A - i[15:0]}, 1'b0);
    end
    // Counts freeze per record, so the newest ones exceed the oldest op time
    u_master.access(1'b0, 16'h404A, 8'h0C, 32'h0, opOld, rerr);
    for (i = 11; i < 14; i++) begin
      u_master.access(1'b0, 16'h4041, i[7:0], 32'h0, rdata, rerr);
      check({31'h0, opOld != 0 && rdata > opOld}, 32'h1);
    end
    wr(16'h40C2, 32'h1, 1'b0);
    rd(16'h40C2, 8'h00, 32'h1, 1'b0);
    rd(16'h404A, 8'h01, 32'h0, 1'b0);
    raise(8'h11, 8'h00);
    u_master.faultReset();
    wr(16'h40C2, 32'h1, 1'b0);
    rd(16'h4041, 8'h01, 32'h11, 1'b0);
    wr(16'h40C2, 32'h0, 1'b0);
    wr(16'h40C2, 32'h1, 1'b0);
    rd(16'h4041, 8'h01, 32'h0, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire

// >>> dv/alarm_master_model.sv
// Fieldbus master and discrete clear wiring of the alarm handler.
// Assumes a one-cycle object request answered two edges later.
`timescale 1ns/1ps
`default_nettype none

module alarm_master_model (
  // Clock
  input wire logic clock,
  // Object answer
  input wire logic objAck_q,
  input wire logic objError_q,
  input wire logic [31:0] objRdata_q,
  // Requests
  output var alarm_pkg::obj_req_type objReq,
  output logic [15:0] controlWord,
  output logic alarmClearInput
);
  initial begin
    objReq = '0;
    controlWord = 16'h0000;
    alarmClearInput = 1'b0;
  end

  // ----
  // Access
  // ----
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    @(posedge clock);
    #1 objReq = '{!wr, wr, idx, sub, wd};
    @(posedge clock);
    // Released fields are inverted so a stale address never looks live
    #1 objReq = '{1'b0, 1'b0, ~idx, ~sub, ~wd};
    for (n = 0; n < 4 && objAck_q !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    rd = (objAck_q === 1'b1) ? objRdata_q : 'x;
    err = objError_q;
  endtask

  task automatic faultReset();
    @(posedge clock);
    #1 controlWord[7] = 1'b1;
    repeat (3) @(posedge clock);
    #1 controlWord[7] = 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic setClear(input logic v);
    @(posedge clock);
    #1 alarmClearInput = v;
    repeat (3) @(posedge clock);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> src/alarm_cfg.svh
// Constants of the alarm handler: object indices, field layout, codes and timing.
// Assumes inclusion by bare name from the package and the alarm handler module.
`ifndef ALARM_CFG_SVH
`define ALARM_CFG_SVH

// Object dictionary indices
`define OBJ_CONTROL_WORD 16'h6040
`define OBJ_HIST_FIRST 16'h4041
`define OBJ_HIST_LAST 16'h404A
`define OBJ_HIST_ERASE 16'h40C2

// Field positions and counts
`define FAULT_RESET_BIT 7
`define HIST_DEPTH 10
`define HIST_FIELDS 8'h0F
`define ERASE_RESET 8'h00

// Alarm codes
`define CODE_OPDATA 8'h70
`define CODE_OVERCURRENT 8'h20

// Timing
`define CLK_HZ 25000000
`define BLINK_HALF_MS 250
`define TICK_MS 1

`endif

// >>> src/alarm_handler_with_history.sv
// Alarm handler of a motor drive with a ten-record alarm history.
// Assumes alarm requests, I/O states and object requests synchronous to clock.
`include "alarm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module alarm_handler_with_history #(
  parameter int DEPTH = `HIST_DEPTH,
  parameter logic [7:0] ABS_POS_CODE = 8'h00,
  parameter int BLINK_CYCLES = (`CLK_HZ / 1000) * `BLINK_HALF_MS,
  parameter int TICK_CYCLES = (`CLK_HZ / 1000) * `TICK_MS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Alarm sources
  input wire logic alarmRaise,
  input wire logic [7:0] alarmCode,
  input wire logic [7:0] alarmSubCode,
  input wire alarm_pkg::context_type alarmContext,
  // Reset sources
  input wire logic [15:0] controlWord,
  input wire logic alarmClearInput,
  input wire logic presetDone,
  input wire logic homingDone,
  // Live states
  input wire logic [15:0] physicalInputs,
  input wire logic [15:0] remoteOutputs,
  input wire logic operationRunning,
  input wire logic mainPowerOn,
  // Object access
  input wire alarm_pkg::obj_req_type objReq,
  output logic objAck_q,
  output logic objError_q,
  output logic [31:0] objRdata_q,
  // Drive outputs
  output logic alarmOutputA_q,
  output logic alarmOutputB_q,
  output logic motorStop_q,
  output logic motorExcite_q,
  output logic powerFaultLampGreen_q,
  output logic powerFaultLampRed_q,
  output logic alarmActive_q,
  output logic [7:0] activeCode_q
);

  localparam int AW = $clog2(DEPTH);
  localparam int RW = $bits(alarm_pkg::record_type);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rstMeta_q;
  logic rstSync_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection of reset requests
  // ----------------------------------------------------------------
  logic faultBit_q;
  logic clearIn_q;
  logic [15:0] remoteOut_q;
  logic faultEdge;
  logic clearEdge;

  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      faultBit_q <= 1'b0;
      clearIn_q <= 1'b0;
    end else begin
      faultBit_q <= controlWord[`FAULT_RESET_BIT];
      clearIn_q <= alarmClearInput;
    end
  end

  assign faultEdge = controlWord[`FAULT_RESET_BIT] && !faultBit_q;
  assign clearEdge = alarmClearInput && !clearIn_q;

  // Tracked every cycle whatever the network state
  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      remoteOut_q <= 16'h0000;
    end else begin
      remoteOut_q <= remoteOutputs;
    end
  end

  // ----------------------------------------------------------------
  // Alarm state
  // ----------------------------------------------------------------
  alarm_pkg::state_type state_q;
  logic latching;
  logic anyReset;
  logic posReset;

  // Overcurrent needs a power restart, as does any code listed here
  assign latching = (alarmCode == `CODE_OVERCURRENT);
  assign anyReset = faultEdge || clearEdge;
  assign posReset = (presetDone || homingDone) && (activeCode_q == ABS_POS_CODE);

  // A new alarm wins over a reset that lands in the same cycle
  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      state_q <= alarm_pkg::ST_NORMAL;
      activeCode_q <= 8'h00;
    end else begin
      case (state_q)
        alarm_pkg::ST_NORMAL: begin
          if (alarmRaise) begin
            state_q <= latching ? alarm_pkg::ST_LOCKED : alarm_pkg::ST_ALARM;
            activeCode_q <= alarmCode;
          end
        end
        alarm_pkg::ST_ALARM: begin
          if (alarmRaise) begin
            state_q <= latching ? alarm_pkg::ST_LOCKED : alarm_pkg::ST_ALARM;
            activeCode_q <= alarmCode;
          end else if (anyReset || posReset) begin
            state_q <= alarm_pkg::ST_NORMAL;
            activeCode_q <= 8'h00;
          end
        end
        alarm_pkg::ST_LOCKED: begin
          state_q <= alarm_pkg::ST_LOCKED;
        end
        default: begin
          state_q <= alarm_pkg::ST_NORMAL;
          activeCode_q <= 8'h00;
        end
      endcase
    end
  end

  logic alarmNow;
  assign alarmNow = (state_q != alarm_pkg::ST_NORMAL);

  // ----------------------------------------------------------------
  // Drive outputs and lamp
  // ----------------------------------------------------------------
  logic [31:0] blinkCnt_q;
  logic blinkPhase_q;

  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      alarmOutputA_q <= 1'b0;
      alarmOutputB_q <= 1'b0;
      motorStop_q <= 1'b1;
      motorExcite_q <= 1'b0;
      alarmActive_q <= 1'b0;
    end else begin
      alarmOutputA_q <= alarmNow;
      alarmOutputB_q <= !alarmNow;
      motorStop_q <= alarmNow;
      motorExcite_q <= !alarmNow;
      alarmActive_q <= alarmNow;
    end
  end

  // Blink restarts with the red phase on every new alarm
  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      blinkCnt_q <= 32'h00000000;
      blinkPhase_q <= 1'b0;
    end else if (alarmRaise || !alarmNow) begin
      blinkCnt_q <= 32'h00000000;
      blinkPhase_q <= 1'b1;
    end else if (blinkCnt_q == 32'(BLINK_CYCLES - 1)) begin
      blinkCnt_q <= 32'h00000000;
      blinkPhase_q <= !blinkPhase_q;
    end else begin
      blinkCnt_q <= blinkCnt_q + 32'h00000001;
    end
  end

  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      powerFaultLampGreen_q <= 1'b0;
      powerFaultLampRed_q <= 1'b0;
    end else begin
      powerFaultLampGreen_q <= !alarmNow && !alarmRaise;
      powerFaultLampRed_q <= alarmRaise || (alarmNow && blinkPhase_q);
    end
  end

  // ----------------------------------------------------------------
  // Elapsed time counters
  // ----------------------------------------------------------------
  logic [31:0] tickCnt_q;
  logic tick;
  logic [31:0] bootTime_q;
  logic [31:0] opTime_q;
  logic [31:0] mainTime_q;

  assign tick = (tickCnt_q == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      tickCnt_q <= 32'h00000000;
    end else begin
      tickCnt_q <= tick ? 32'h00000000 : tickCnt_q + 32'h00000001;
    end
  end

  // Counts are in ticks; they wrap rather than saturate
  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      bootTime_q <= 32'h00000000;
      opTime_q <= 32'h00000000;
      mainTime_q <= 32'h00000000;
    end else begin
      if (tick) begin
        bootTime_q <= bootTime_q + 32'h00000001;
      end
      if (!operationRunning) begin
        opTime_q <= 32'h00000000;
      end else if (tick) begin
        opTime_q <= opTime_q + 32'h00000001;
      end
      if (!mainPowerOn) begin
        mainTime_q <= 32'h00000000;
      end else if (tick) begin
        mainTime_q <= mainTime_q + 32'h00000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Record capture
  // ----------------------------------------------------------------
  alarm_pkg::record_type newRecord;

  always_comb begin
    newRecord.code = alarmCode;
    // Cause field only meaningful to users for operation-data alarms
    newRecord.subCode = alarmSubCode;
    newRecord.driverTemp = alarmContext.driverTemp;
    newRecord.motorTemp = alarmContext.motorTemp;
    newRecord.inverterVolt = alarmContext.inverterVolt;
    newRecord.feedbackPos = alarmContext.feedbackPos;
    newRecord.physIn = physicalInputs;
    newRecord.remoteOut = remoteOut_q;
    newRecord.opDataNum = alarmContext.opDataNum;
    newRecord.opKind = alarmContext.opKind;
    newRecord.bootTime = bootTime_q;
    newRecord.opTime = opTime_q;
    newRecord.mainTime = mainTime_q;
    newRecord.motorModel = alarmContext.motorModel;
    newRecord.motorSerial = alarmContext.motorSerial;
  end

  // ----------------------------------------------------------------
  // History pointers and erase object
  // ----------------------------------------------------------------
  logic [AW-1:0] wrPtr_q;
  logic [AW:0] count_q;
  logic [7:0] erase_q;
  logic eraseWrite;
  logic eraseEdge;

  assign eraseWrite = objReq.write && (objReq.index == `OBJ_HIST_ERASE);
  assign eraseEdge = eraseWrite && (erase_q == 8'h00) && (objReq.wdata[7:0] == 8'h01);

  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      erase_q <= `ERASE_RESET;
    end else if (eraseWrite) begin
      erase_q <= objReq.wdata[7:0];
    end
  end

  // Ring buffer: a full store overwrites the oldest slot, which reads as a shift
  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      wrPtr_q <= '0;
      count_q <= '0;
    end else if (alarmRaise) begin
      wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + AW'(1);
      if (count_q != (AW + 1)'(DEPTH)) begin
        count_q <= count_q + (AW + 1)'(1);
      end
    end else if (eraseEdge) begin
      wrPtr_q <= '0;
      count_q <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Object reads
  // ----------------------------------------------------------------
  logic histHit;
  logic [AW:0] age;
  logic [AW:0] slotSum;
  logic [AW-1:0] readSlot;
  logic pend_q;
  logic pendHist_q;
  logic pendValid_q;
  logic [7:0] pendSub_q;
  logic [31:0] pendOther_q;
  logic pendError_q;
  logic [RW-1:0] memData;
  alarm_pkg::record_type rec;

  assign histHit = (objReq.index >= `OBJ_HIST_FIRST) && (objReq.index <= `OBJ_HIST_LAST);
  assign age = (AW + 1)'(objReq.index - `OBJ_HIST_FIRST);
  assign slotSum = {1'b0, wrPtr_q} + (AW + 1)'(DEPTH - 1) - age;
  assign readSlot = (slotSum >= (AW + 1)'(DEPTH)) ? AW'(slotSum - (AW + 1)'(DEPTH)) : AW'(slotSum);

  alarm_history_mem #(
    .WIDTH(RW),
    .DEPTH(DEPTH),
    .AW(AW)
  ) historyMem (
    .clock(clock),
    .writeEn(alarmRaise),
    .writeAddr(wrPtr_q),
    .writeData(newRecord),
    .readAddr(readSlot),
    .readData_q(memData)
  );

  assign rec = memData;

  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      pend_q <= 1'b0;
      pendHist_q <= 1'b0;
      pendValid_q <= 1'b0;
      pendSub_q <= 8'h00;
      pendOther_q <= 32'h00000000;
      pendError_q <= 1'b0;
    end else begin
      pend_q <= objReq.read || objReq.write;
      pendHist_q <= objReq.read && histHit;
      pendValid_q <= age < count_q;
      pendSub_q <= objReq.sub;
      pendOther_q <= (objReq.read && objReq.index == `OBJ_HIST_ERASE) ? {24'h000000, erase_q}
                                                                       : 32'h00000000;
      // Records are read-only; text is never offered, so unknown objects fail
      pendError_q <= (objReq.read && !histHit && objReq.index != `OBJ_HIST_ERASE)
                  || (objReq.write && !eraseWrite)
                  || (objReq.read && histHit && objReq.sub > `HIST_FIELDS);
    end
  end

  logic [31:0] fieldData;

  // Sub-index 0 gives the field count; unfilled slots read as zero
  always_comb begin
    case (pendSub_q)
      8'h00: fieldData = {24'h000000, `HIST_FIELDS};
      8'h01: fieldData = {24'h000000, rec.code};
      8'h02: fieldData = {24'h000000, rec.subCode};
      8'h03: fieldData = {16'h0000, rec.driverTemp};
      8'h04: fieldData = {16'h0000, rec.motorTemp};
      8'h05: fieldData = {16'h0000, rec.inverterVolt};
      8'h06: fieldData = {16'h0000, rec.physIn};
      8'h07: fieldData = {16'h0000, rec.remoteOut};
      8'h08: fieldData = {16'h0000, rec.opDataNum};
      8'h09: fieldData = {16'h0000, rec.opKind};
      8'h0A: fieldData = rec.feedbackPos;
      8'h0B: fieldData = rec.bootTime;
      8'h0C: fieldData = rec.opTime;
      8'h0D: fieldData = rec.mainTime;
      8'h0E: fieldData = rec.motorModel;
      8'h0F: fieldData = rec.motorSerial;
      default: fieldData = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      objAck_q <= 1'b0;
      objError_q <= 1'b0;
      objRdata_q <= 32'h00000000;
    end else begin
      objAck_q <= pend_q;
      objError_q <= pend_q && pendError_q;
      if (pendHist_q && !pendError_q) begin
        objRdata_q <= (pendValid_q || pendSub_q == 8'h00) ? fieldData : 32'h00000000;
      end else begin
        objRdata_q <= pendOther_q;
      end
    end
  end

endmodule

`default_nettype wire

// >>> src/alarm_history_mem.sv
// Record store for the alarm history: one write port, one registered read port.
// Assumes the caller keeps write and read addresses below DEPTH.
`timescale 1ns/1ps
`default_nettype none

module alarm_history_mem #(
  parameter int WIDTH = 320,
  parameter int DEPTH = 10,
  parameter int AW = 4
) (
  // Clock
  input wire logic clock,
  // Write port
  input wire logic writeEn,
  input wire logic [AW-1:0] writeAddr,
  input wire logic [WIDTH-1:0] writeData,
  // Read port
  input wire logic [AW-1:0] readAddr,
  output logic [WIDTH-1:0] readData_q
);

  logic [WIDTH-1:0] store [DEPTH];

  // Contents carry no reset, as a nonvolatile array would not
  always_ff @(posedge clock) begin
    if (writeEn) begin
      store[writeAddr] <= writeData;
    end
  end

  always_ff @(posedge clock) begin
    readData_q <= store[readAddr];
  end

endmodule

`default_nettype wire

// >>> src/alarm_pkg.sv
// Types shared by the alarm handler, its checker, master model and test bench.
// Assumes alarm_cfg.svh is on the include path.
`include "alarm_cfg.svh"

package alarm_pkg;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] subCode;
    logic [15:0] driverTemp;
    logic [15:0] motorTemp;
    logic [15:0] inverterVolt;
    logic [15:0] physIn;
    logic [15:0] remoteOut;
    logic [15:0] opDataNum;
    logic [15:0] opKind;
    logic [31:0] feedbackPos;
    logic [31:0] bootTime;
    logic [31:0] opTime;
    logic [31:0] mainTime;
    logic [31:0] motorModel;
    logic [31:0] motorSerial;
  } record_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] wdata;
  } obj_req_type;

  typedef struct packed {
    logic [15:0] driverTemp;
    logic [15:0] motorTemp;
    logic [15:0] inverterVolt;
    logic [31:0] feedbackPos;
    logic [15:0] opDataNum;
    logic [15:0] opKind;
    logic [31:0] motorModel;
    logic [31:0] motorSerial;
  } context_type;

  typedef enum logic [2:0] {
    ST_NORMAL = 3'b001,
    ST_ALARM = 3'b010,
    ST_LOCKED = 3'b100
  } state_type;

endpackage
